// ### tscb_capture.sv
// capture engine: rate generation, trigger handling, circular store, regs
// Function
// - memory is built from 2 kbyte blocks of 512 four-byte words.
// - total length from one 2 kbyte block up to 4 Mbytes.
// - samples stored and read back as 32-bit little endian floats.
// - all selected quantities sampled on one instant at one rate.
// - peak periodic rate follows the filter time constant table.
// - periodic rate is peak rate divided by two to the exponent 0..20.
// - time constant change retunes the rate at once, capture continues.
// - per-trigger mode ignores exponent, stores one sample per edge.
// - single-fill stops when length written; halt may stop it early.
// - wrap-around returns to address zero and overwrites oldest data.
// - halt or trigger stop zero-fills current block before ending.
// - readable count of real sample bytes, zero fill excluded.
// - single-fill with trigger waits for falling edge; trigger never stops.
// - wrap-around with trigger ends capture on a falling edge.
// - immediate mode records at start; ends on full or halt.
// - per-trigger stores one sample per falling edge; ends full or halt.
// - length in kbytes 1..4096, odd values rounded up to even.
// - selection 0 X, 1 XY, 2 R theta, 3 all; rate unchanged.
// - peak rate readable in hertz, including sync filter reduction.
// - rate read-back returns actual hertz, not the exponent.
// - state and byte count readable while recording.
// - 3-bit state: recording, triggered, wrapped.
// - new start discards old data and resets capture state.
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

module tscb_capture
    import tscb_pkg::*;
#(
    parameter int MEM_WORDS = 1048576,
    parameter int PTR_W = 20
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire tscb_sample_type sampleIn,
    input wire logic [3:0] timeConstIdx,
    input wire logic [3:0] syncFilterShift,
    input wire logic external_trigger_input
);

    // ****************************************************************
    // helper functions
    // ****************************************************************
    // peak rate in whole hertz per time constant class
    function automatic logic [31:0] peak_hz(input logic [3:0] idx);
        case (idx)
            4'h0: peak_hz = 32'h001312d0;   // 1.25 MHz
            4'h1: peak_hz = 32'h00098968;   // 625 kHz
            4'h2: peak_hz = 32'h0004f588;   // 325 kHz
            4'h3: peak_hz = 32'h0002625a;   // 156.25 kHz
            4'h4: peak_hz = 32'h0001312d;   // 78.125 kHz
            4'h5: peak_hz = 32'h00009896;   // 39.0625 kHz
            4'h6: peak_hz = 32'h00002625;   // 9765.62 Hz
            4'h7: peak_hz = 32'h00000989;   // 2441.41 Hz
            4'h8: peak_hz = 32'h000004c4;   // 1220.7 Hz
            4'h9: peak_hz = 32'h00000131;   // 305.18 Hz
            default: peak_hz = 32'h00000098;  // 152.59 Hz
        endcase
    endfunction : peak_hz

    // halvings of the 1.25 MHz tick per class; 325 kHz uses the /4 tick
    function automatic logic [4:0] peak_shift(input logic [3:0] idx);
        case (idx)
            4'h0: peak_shift = 5'h00;
            4'h1: peak_shift = 5'h01;
            4'h2: peak_shift = 5'h02;
            4'h3: peak_shift = 5'h03;
            4'h4: peak_shift = 5'h04;
            4'h5: peak_shift = 5'h05;
            4'h6: peak_shift = 5'h07;
            4'h7: peak_shift = 5'h09;
            4'h8: peak_shift = 5'h0a;
            4'h9: peak_shift = 5'h0c;
            default: peak_shift = 5'h0d;
        endcase
    endfunction : peak_shift

    // words stored per sample instant for a selection code
    function automatic logic [2:0] words_of(input logic [1:0] sel);
        case (sel)
            2'h0: words_of = 3'h1;
            2'h3: words_of = 3'h4;
            default: words_of = 3'h2;
        endcase
    endfunction : words_of

    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0] mem [MEM_WORDS];
    tscb_state_type state_reg;
    logic waitReq_reg;
    logic [31:0] readData_reg;
    logic [12:0] lenKb_reg;
    logic [1:0] selection_reg;
    logic [4:0] rateExp_reg;
    logic acqWrap_reg;
    logic [1:0] mode_reg;
    logic [2:0] stat_reg;
    logic [31:0] realBytes_reg;
    logic [PTR_W-1:0] wordPtr_reg;
    logic [2:0] pending_reg;
    logic [127:0] sampleShift_reg;
    logic [31:0] tickCnt_reg;
    logic [19:0] prescale_reg;
    logic [PTR_W-1:0] rdAddr_reg;
    logic trigMeta_reg;
    logic trigSync_reg;
    logic trigPrev_reg;

    logic busWrite;
    logic startCmd;
    logic haltCmd;
    logic resetCmd;
    logic [20:0] lenWords;
    logic lastWord;
    logic [4:0] tickShift;
    logic [31:0] tickPeriod;
    logic maxTick;
    logic strobe;
    logic trigFall;
    logic takeSample;
    logic memWe;
    logic [31:0] memWd;

    // ****************************************************************
    // avalon slave: one wait state, then the request is taken
    // ****************************************************************
    assign busWrite = avs_write && !waitReq_reg;
    assign startCmd = busWrite && avs_address == OFF_CTRL &&
        avs_writedata[CTRL_START_BIT];
    assign haltCmd = busWrite && avs_address == OFF_CTRL &&
        avs_writedata[CTRL_HALT_BIT] && !avs_writedata[CTRL_START_BIT];
    // length or selection writes reset the capture system as well
    assign resetCmd = busWrite &&
        (avs_address == OFF_LEN || avs_address == OFF_CFG);

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waitReq_reg <= 1'b1;
        end else if ((avs_read || avs_write) && waitReq_reg) begin
            waitReq_reg <= 1'b0;
        end else begin
            waitReq_reg <= 1'b1;
        end
    end
    assign avs_waitrequest = waitReq_reg;

    // read data is prepared while waitrequest is still high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readData_reg <= 32'h00000000;
        end else if (avs_read && waitReq_reg) begin
            case (avs_address)
                OFF_CTRL: readData_reg <= {27'h0000000, acqWrap_reg,
                    mode_reg, 2'h0};
                OFF_LEN: readData_reg <= {19'h00000, lenKb_reg};
                OFF_CFG: readData_reg <= {30'h00000000, selection_reg};
                OFF_RATE: readData_reg <= (peak_hz(timeConstIdx) >>
                    syncFilterShift) >> rateExp_reg;
                OFF_PEAK: readData_reg <= peak_hz(timeConstIdx) >>
                    syncFilterShift;
                OFF_BYTES: readData_reg <= realBytes_reg;
                OFF_STAT: readData_reg <= {29'h00000000, stat_reg};
                OFF_RDADDR: readData_reg <= 32'(rdAddr_reg);
                OFF_RDDATA: readData_reg <= mem[rdAddr_reg];
                default: readData_reg <= 32'h00000000;
            endcase
        end
    end
    assign avs_readdata = readData_reg;

    // configuration registers; odd length rounds up, range clamped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lenKb_reg <= LEN_KB_RESET;
            selection_reg <= 2'h0;
            rateExp_reg <= 5'h00;
            rdAddr_reg <= '0;
        end else if (busWrite) begin
            case (avs_address)
                OFF_LEN: begin
                    if (avs_writedata > 32'(LEN_KB_MAX)) begin
                        lenKb_reg <= 13'(LEN_KB_MAX);
                    end else if (avs_writedata[12:0] == 13'h0000) begin
                        lenKb_reg <= LEN_KB_RESET;
                    end else begin
                        lenKb_reg <= avs_writedata[12:0] +
                            {12'h000, avs_writedata[0]};
                    end
                end
                OFF_CFG: selection_reg <= avs_writedata[1:0];
                OFF_RATE: begin
                    if (avs_writedata > 32'(EXP_MAX)) begin
                        rateExp_reg <= 5'(EXP_MAX);
                    end else begin
                        rateExp_reg <= avs_writedata[4:0];
                    end
                end
                OFF_RDADDR: rdAddr_reg <= avs_writedata[PTR_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // trigger synchroniser and falling edge detector
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trigMeta_reg <= 1'b1;
            trigSync_reg <= 1'b1;
            trigPrev_reg <= 1'b1;
        end else begin
            trigMeta_reg <= external_trigger_input;
            trigSync_reg <= trigMeta_reg;
            trigPrev_reg <= trigSync_reg;
        end
    end
    assign trigFall = trigPrev_reg && !trigSync_reg;

    // ****************************************************************
    // peak-rate tick and power-of-two prescaler
    // ****************************************************************
    // the period is re-evaluated every cycle so a new time constant
    // takes hold at once without restarting the capture
    assign tickShift = peak_shift(timeConstIdx) + {1'b0, syncFilterShift};
    assign tickPeriod = 32'(MAX_TICK_CYC) << tickShift;
    assign maxTick = tickCnt_reg + 32'h00000001 >= tickPeriod;

    always_ff @(posedge clk) begin
        if (sys_rst || startCmd || maxTick) begin
            tickCnt_reg <= 32'h00000000;
        end else begin
            tickCnt_reg <= tickCnt_reg + 32'h00000001;
        end
    end

    // prescaler restarts with each capture
    always_ff @(posedge clk) begin
        if (sys_rst || startCmd) begin
            prescale_reg <= 20'h00000;
        end else if (maxTick) begin
            prescale_reg <= prescale_reg + 20'h00001;
        end
    end
    assign strobe = maxTick &&
        (prescale_reg & ((20'h00001 << rateExp_reg) - 20'h00001)) ==
        20'h00000;

    // ****************************************************************
    // acquisition state machine
    // ****************************************************************
    assign lenWords = 21'(lenKb_reg) * 21'(WORDS_PER_KB);
    assign lastWord = 21'(wordPtr_reg) == lenWords - 21'h000001;
    // a sample is dropped if the previous one is still being stored
    assign takeSample = state_reg == ST_RUN && pending_reg == 3'h0 &&
        (mode_reg == MODE_PER_TRIGGER ? trigFall : strobe);
    // zero fill stops short of the boundary so the next block stays clean
    assign memWe = pending_reg != 3'h0 || (state_reg == ST_FILL &&
        wordPtr_reg[BLOCK_BITS-1:0] != '0);
    assign memWd = pending_reg != 3'h0 ? sampleShift_reg[31:0] :
        32'h00000000;

    always_ff @(posedge clk) begin
        if (sys_rst || resetCmd) begin
            state_reg <= ST_IDLE;
        end else if (startCmd) begin
            // triggered single-fill waits for the edge
            if (!avs_writedata[CTRL_ACQ_BIT] &&
                avs_writedata[CTRL_MODE_LSB+:2] == MODE_TRIGGERED) begin
                state_reg <= ST_ARMED;
            end else begin
                state_reg <= ST_RUN;
            end
        end else begin
            case (state_reg)
                ST_ARMED: begin
                    if (haltCmd) begin
                        state_reg <= ST_IDLE;
                    end else if (trigFall) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (memWe && lastWord && !acqWrap_reg) begin
                        state_reg <= ST_DONE;
                    end else if (haltCmd || (acqWrap_reg &&
                        mode_reg == MODE_TRIGGERED && trigFall)) begin
                        state_reg <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    // zero words run to the next block boundary
                    if (pending_reg == 3'h0 &&
                        wordPtr_reg[BLOCK_BITS-1:0] == '0) begin
                        state_reg <= ST_DONE;
                    end
                end
                default: ;
            endcase
        end
    end

    // capture kind latched on start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acqWrap_reg <= ACQ_SINGLE;
            mode_reg <= MODE_IMMEDIATE;
        end else if (startCmd) begin
            acqWrap_reg <= avs_writedata[CTRL_ACQ_BIT];
            mode_reg <= avs_writedata[CTRL_MODE_LSB+:2];
        end
    end

    // sample latch: every selected quantity from one instant
    always_ff @(posedge clk) begin
        if (sys_rst || startCmd || resetCmd) begin
            pending_reg <= 3'h0;
            sampleShift_reg <= '0;
        end else if (takeSample) begin
            pending_reg <= words_of(selection_reg);
            case (selection_reg)
                2'h2: sampleShift_reg <= {64'h0, sampleIn.theta, sampleIn.r};
                default: sampleShift_reg <= sampleIn;
            endcase
        end else if (pending_reg != 3'h0 && state_reg != ST_DONE) begin
            pending_reg <= pending_reg - 3'h1;
            sampleShift_reg <= {32'h00000000, sampleShift_reg[127:32]};
        end
    end

    // write pointer and memory port; pointer wraps to zero
    always_ff @(posedge clk) begin
        if (sys_rst || startCmd || resetCmd) begin
            wordPtr_reg <= '0;
        end else if (memWe && state_reg != ST_DONE) begin
            if (lastWord) begin
                wordPtr_reg <= '0;
            end else begin
                wordPtr_reg <= wordPtr_reg + 1'b1;
            end
        end
    end

    // storage only; word order is low byte first on the bus
    always_ff @(posedge clk) begin
        if (memWe && state_reg != ST_DONE && !startCmd && !resetCmd) begin
            mem[wordPtr_reg] <= memWd;
        end
    end

    // real byte count: zero fill excluded, drops one block on overwrite
    always_ff @(posedge clk) begin
        if (sys_rst || startCmd || resetCmd) begin
            realBytes_reg <= 32'h00000000;
        end else if (pending_reg != 3'h0 && state_reg != ST_DONE) begin
            if (stat_reg[STAT_WRAP_BIT] &&
                wordPtr_reg[BLOCK_BITS-1:0] == '0) begin
                realBytes_reg <= realBytes_reg -
                    32'(BLOCK_BYTES - WORD_BYTES);
            end else begin
                realBytes_reg <= realBytes_reg + 32'(WORD_BYTES);
            end
        end
    end

    // state word: recording, triggered, wrapped
    always_ff @(posedge clk) begin
        if (sys_rst || startCmd || resetCmd) begin
            stat_reg <= 3'h0;
        end else begin
            stat_reg[STAT_REC_BIT] <= state_reg == ST_RUN ||
                state_reg == ST_FILL;
            if (state_reg == ST_RUN) begin
                stat_reg[STAT_TRIG_BIT] <= 1'b1;
            end
            if (memWe && lastWord && state_reg != ST_DONE) begin
                stat_reg[STAT_WRAP_BIT] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_trigPulse;
        @(posedge clk) disable iff (sys_rst)
        trigFall |=> !trigFall;
    endproperty
    a_trigPulse: assert property (p_trigPulse)
        else $error("trigger pulse longer than one cycle");

    property p_lenEven;
        @(posedge clk) disable iff (sys_rst)
        !lenKb_reg[0] && lenKb_reg >= 13'h0002 && lenKb_reg <= 13'h1000;
    endproperty
    a_lenEven: assert property (p_lenEven)
        else $error("length not even or out of range");

    property p_startClears;
        @(posedge clk) disable iff (sys_rst)
        startCmd |=> realBytes_reg == 32'h0 && wordPtr_reg == '0;
    endproperty
    a_startClears: assert property (p_startClears)
        else $error("start did not clear capture");

    property p_fillZero;
        @(posedge clk) disable iff (sys_rst)
        state_reg == ST_FILL && pending_reg == 3'h0 |-> memWd == 32'h0 &&
            memWe == (wordPtr_reg[BLOCK_BITS-1:0] != '0);
    endproperty
    a_fillZero: assert property (p_fillZero)
        else $error("fill word not zero");

    property p_doneOnBlock;
        @(posedge clk) disable iff (sys_rst)
        $past(state_reg) == ST_FILL && state_reg == ST_DONE |->
            wordPtr_reg[BLOCK_BITS-1:0] == '0;
    endproperty
    a_doneOnBlock: assert property (p_doneOnBlock)
        else $error("capture ended off a block boundary");

    property p_singleStop;
        @(posedge clk) disable iff (sys_rst)
        state_reg == ST_RUN && !acqWrap_reg && memWe && lastWord &&
            !startCmd && !resetCmd |=> state_reg == ST_DONE ##1
            stat_reg == 3'h6;
    endproperty
    a_singleStop: assert property (p_singleStop)
        else $error("single fill did not stop when full");

    property p_wrapPtr;
        @(posedge clk) disable iff (sys_rst)
        state_reg == ST_RUN && acqWrap_reg && memWe && lastWord &&
            !startCmd && !resetCmd |=> wordPtr_reg == '0;
    endproperty
    a_wrapPtr: assert property (p_wrapPtr)
        else $error("pointer did not return to zero");

    property p_armedIdle;
        @(posedge clk) disable iff (sys_rst)
        state_reg == ST_ARMED |-> stat_reg == 3'h0 && !memWe;
    endproperty
    a_armedIdle: assert property (p_armedIdle)
        else $error("recording before start trigger");

    property p_perTrig;
        @(posedge clk) disable iff (sys_rst)
        takeSample && mode_reg == MODE_PER_TRIGGER && !startCmd &&
            !resetCmd |-> trigFall ##1 pending_reg ==
            words_of(selection_reg);
    endproperty
    a_perTrig: assert property (p_perTrig)
        else $error("per-trigger sample not taken");

    property p_busAnswer;
        @(posedge clk) disable iff (sys_rst)
        (avs_read || avs_write) && waitReq_reg |=> !waitReq_reg ##1
            waitReq_reg;
    endproperty
    a_busAnswer: assert property (p_busAnswer)
        else $error("bus answer not after one wait state");

    c_wrapStop: cover property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_FILL && acqWrap_reg && stat_reg[STAT_WRAP_BIT]);
    c_singleDone: cover property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_DONE && !acqWrap_reg);
    c_armedStart: cover property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_ARMED ##1 state_reg == ST_RUN);

endmodule : tscb_capture

// ### tscb_pkg.sv
// package of constants and types for the triggered sample capture buffer
package tscb_pkg;

    // ****************************************************************
    // register map (byte addresses) and bus geometry
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LEN = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam logic [7:0] OFF_RATE = 8'h0c;
    localparam logic [7:0] OFF_PEAK = 8'h10;
    localparam logic [7:0] OFF_BYTES = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] OFF_RDADDR = 8'h1c;
    localparam logic [7:0] OFF_RDDATA = 8'h20;

    // control word fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_HALT_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_ACQ_BIT = 4;

    // status word fields
    localparam int STAT_REC_BIT = 0;
    localparam int STAT_TRIG_BIT = 1;
    localparam int STAT_WRAP_BIT = 2;

    // ****************************************************************
    // memory geometry
    // ****************************************************************
    localparam int BLOCK_BYTES = 2048;
    localparam int BLOCK_WORDS = 512;
    localparam int BLOCK_BITS = 9;
    localparam int WORDS_PER_KB = 256;
    localparam int LEN_KB_MAX = 4096;
    localparam logic [12:0] LEN_KB_RESET = 13'h0002;
    localparam int WORD_BYTES = 4;

    // ****************************************************************
    // rates and timing
    // ****************************************************************
    localparam int CLK_HZ = 100000000;
    localparam int RATE_MAX_HZ = 1250000;
    localparam int MAX_TICK_CYC = CLK_HZ / RATE_MAX_HZ;
    localparam int EXP_MAX = 20;

    // acquisition kind and start mode encodings
    localparam logic ACQ_SINGLE = 1'b0;
    localparam logic ACQ_WRAP = 1'b1;
    localparam logic [1:0] MODE_IMMEDIATE = 2'h0;
    localparam logic [1:0] MODE_TRIGGERED = 2'h1;
    localparam logic [1:0] MODE_PER_TRIGGER = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ARMED, ST_RUN, ST_FILL, ST_DONE
    } tscb_state_type;

    // one instant of demodulated outputs, each a 32-bit float
    typedef struct packed {
        logic [31:0] theta;
        logic [31:0] r;
        logic [31:0] y;
        logic [31:0] x;
    } tscb_sample_type;

endpackage : tscb_pkg

// ### tscb_trig_src.sv
// external trigger source model for the capture bench
`timescale 1ns/1ps
// ****************************************************************
// trigger source
// ****************************************************************
module tscb_trig_src (
    input wire logic clk,
    input wire logic fireReq,
    output logic trigPin
);
    logic [2:0] lowCnt_reg = 3'h0;
    // one low pulse per request; the bench spaces requests far apart
    always_ff @(posedge clk) begin
        if (fireReq) begin
            lowCnt_reg <= 3'h4;
        end else if (lowCnt_reg != 3'h0) begin
            lowCnt_reg <= lowCnt_reg - 3'h1;
        end
    end
    // pull-up holds the pin high between pulses
    assign trigPin = (lowCnt_reg == 3'h0);
endmodule : tscb_trig_src

// ### tb_top.sv
// self-checking bench for the capture engine
`timescale 1ns/1ps
// ****************************************************************
// bench
// ****************************************************************
module tb_top;
    import tscb_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, trigPin, fireReq = 1'b0;
    logic [3:0] timeConstIdx = 4'h0, syncFilterShift = 4'h0;
    tscb_sample_type sampleIn = {32'h4, 32'h3, 32'h2, 32'h3fc00000};
    int n_mismatch = 0, comparisons = 0;
    // small memory of 4096 words keeps the array small; zero fill still runs to the 512-word block boundary
    tscb_capture #(.MEM_WORDS(4096), .PTR_W(12)) dut_u (.clk(clk),
        .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sampleIn(sampleIn), .timeConstIdx(timeConstIdx),
        .syncFilterShift(syncFilterShift),
        .external_trigger_input(trigPin));
    tscb_trig_src src_u (.clk(clk), .fireReq(fireReq), .trigPin(trigPin));
    always #5 clk = ~clk;
    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rd(input string nm, input logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask : rd
    task automatic fire;
        @(posedge clk);
        fireReq <= 1'b1;
        @(posedge clk);
        fireReq <= 1'b0;
        repeat (100) @(posedge clk);
    endtask : fire
    // reset values, length rounding, rate and peak read-back
    task automatic t_regs;
        rd("len", OFF_LEN, 32'h2);
        bus(1'b1, OFF_LEN, 32'h2000);
        rd("lenMax", OFF_LEN, 32'h1000);
        bus(1'b1, OFF_LEN, 32'h3);
        rd("lenOdd", OFF_LEN, 32'h4);
        rd("peak", OFF_PEAK, 32'(RATE_MAX_HZ));
        bus(1'b1, OFF_RATE, 32'h4);
        rd("rate", OFF_RATE, 32'(RATE_MAX_HZ >> 4));
        timeConstIdx <= 4'h4;
        rd("peak4", OFF_PEAK, 32'h1312d);
        rd("rate4", OFF_RATE, 32'h1312);
        syncFilterShift <= 4'h1;
        rd("peakSync", OFF_PEAK, 32'h9896);
        timeConstIdx <= 4'h0;
        syncFilterShift <= 4'h0;
        rd("unmapped", 8'h40, 32'h0);
    endtask : t_regs
    // triggered single fill waits for the edge
    task automatic t_armed;
        bus(1'b1, OFF_CTRL, 32'h05);
        rd("armed", OFF_STAT, 32'h0);
        fire();
        rd("started", OFF_STAT, 32'h3);
        bus(1'b1, OFF_CTRL, 32'h02);
        repeat (600) @(posedge clk);
    endtask : t_armed
    // one sample per edge, halt zero-fills the block
    task automatic t_pertrig;
        bus(1'b1, OFF_CTRL, 32'h09);
        rd("fresh", OFF_BYTES, 32'h0);
        repeat (3) fire();
        rd("live", OFF_BYTES, 32'hc);
        bus(1'b1, OFF_CTRL, 32'h02);
        repeat (600) @(posedge clk);
        rd("stat", OFF_STAT, 32'h2);
        rd("bytes", OFF_BYTES, 32'hc);
        bus(1'b1, OFF_RDADDR, 32'h2);
        rd("word2", OFF_RDDATA, 32'h3fc00000);
        bus(1'b1, OFF_RDADDR, 32'h3);
        rd("word3", OFF_RDDATA, 32'h0);
    endtask : t_pertrig
    // immediate single fill to full, then wrap-around ended by trigger
    task automatic t_fill;
        bus(1'b1, OFF_LEN, 32'h2);
        bus(1'b1, OFF_CFG, 32'h3);
        bus(1'b1, OFF_RATE, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h01);
        repeat (11000) @(posedge clk);
        rd("full", OFF_STAT, 32'h6);
        rd("fullBytes", OFF_BYTES, 32'h800);
        bus(1'b1, OFF_CTRL, 32'h15);
        repeat (11000) @(posedge clk);
        rd("wrapped", OFF_STAT, 32'h7);
        fire();
        repeat (600) @(posedge clk);
        rd("trigStop", OFF_STAT, 32'h6);
        bus(1'b0, OFF_BYTES, 32'h0);
        chk("wrapBytes", 32'(q[3:0] == 4'h0 && q != 0 && q <= 32'h800),
            32'h1);
        bus(1'b1, OFF_RDADDR, 32'h1);
        rd("wordY", OFF_RDDATA, 32'h2);
        bus(1'b1, OFF_RDADDR, 32'h1ff);
        rd("lastZero", OFF_RDDATA, 32'h0);
    endtask : t_fill
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_armed();
        t_pertrig();
        t_fill();
        tally_and_finish();
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_top
